// file: dpf_defs.svh
// Constants for the debug-port flash programming registers.
// Assumes inclusion by the register block and the bench only.
`ifndef DPF_DEFS_SVH
`define DPF_DEFS_SVH
// ---------------------------------------------
// Port register select codes
// ---------------------------------------------
`define DPF_SEL_DEVID 8'h00
`define DPF_SEL_REVID 8'h01
`define DPF_SEL_UNLOCK 8'h02
`define DPF_SEL_DATA 8'hb4
// ---------------------------------------------
// Unlock codes, commands, reset values
// ---------------------------------------------
`define DPF_KEY_FIRST 8'h02
`define DPF_KEY_SECOND 8'h01
`define DPF_CMD_ERASE_ALL 8'h03
`define DPF_CMD_READ 8'h06
`define DPF_CMD_WRITE 8'h07
`define DPF_CMD_PAGE_ERASE 8'h08
`define DPF_RST_BYTE 8'h00
`define DPF_RST_ADDR 16'h0000
`define DPF_RST_CNT 9'h000
`define DPF_CNT_ONE 9'h001
`define DPF_CNT_FULL 9'h100
`define DPF_ADDR_ONE 16'h0001
// Identity values, arbitrary
`define DPF_DEV_ID 8'h5a
`define DPF_REV_ID 8'h0a
`endif

// file: dpf_pkg.sv
// Types for the debug-port flash programming registers.
// Assumes dpf_defs.svh alongside.
package dpf_pkg;
	// Unlock sequence states
	typedef enum logic [1:0] {
		UNL_LOCKED = 2'b00,
		UNL_FIRST = 2'b01,
		UNL_OPEN = 2'b11
	} dpf_unlock_t;
	// Command engine states
	typedef enum logic [2:0] {
		C_IDLE = 3'b000,
		C_ADDR_HI = 3'b001,
		C_ADDR_LO = 3'b011,
		C_LEN = 3'b010,
		C_DATA = 3'b110,
		C_FLASH = 3'b111
	} dpf_cmd_t;
	// Flash operations
	typedef enum logic [1:0] {
		FOP_ERASE_ALL = 2'b00,
		FOP_PAGE_ERASE = 2'b01,
		FOP_READ = 2'b10,
		FOP_WRITE = 2'b11
	} dpf_fop_t;
	// Request toward the flash controller
	typedef struct packed {
		logic valid;
		dpf_fop_t op;
		logic [15:0] addr;
		logic [7:0] wdata;
	} dpf_flash_req_t;
	// Access strobes from the debug port decoder
	typedef struct packed {
		logic addr_wr;
		logic data_wr;
		logic data_rd;
		logic [7:0] wdata;
	} dpf_port_req_t;
endpackage

// file: dpf_prog_regs.sv
// Data registers of the two-wire debug port used for flash programming.
// Assumes the port decoder delivers one-cycle strobes on ref_clk_i.
`include "dpf_defs.svh"

module dpf_prog_regs
	import dpf_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Debug port access
	input wire dpf_port_req_t port_req_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	// Status
	output logic prog_enable_o,
	output logic busy_o,
	// Flash controller
	output dpf_flash_req_t flash_req_o,
	input wire logic flash_done_i,
	input wire logic [7:0] flash_rdata_i
);
	// ---------------------------------------------
	// State
	// ---------------------------------------------
	logic [7:0] sel_reg;
	logic [7:0] unlock_reg;
	logic [7:0] unlock_next;
	dpf_unlock_t unl_state_reg;
	dpf_unlock_t unl_state_next;
	logic prog_en_reg;
	dpf_cmd_t cmd_state_reg;
	dpf_cmd_t cmd_state_next;
	dpf_fop_t cmd_op_reg;
	dpf_fop_t cmd_op_next;
	logic [15:0] faddr_reg;
	logic [15:0] faddr_next;
	logic [8:0] count_reg;
	logic [8:0] count_next;
	logic [7:0] data_reg;
	logic [7:0] data_next;
	dpf_flash_req_t freq_reg;
	dpf_flash_req_t freq_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic rvalid_reg;
	logic busy_reg;
	logic start;

	// ---------------------------------------------
	// Access decode
	// ---------------------------------------------
	// Strobes come only from the debug port, never the firmware space
	wire unl_wr = port_req_i.data_wr && (sel_reg == `DPF_SEL_UNLOCK);
	wire dat_wr = port_req_i.data_wr && (sel_reg == `DPF_SEL_DATA);
	wire dat_rd = port_req_i.data_rd && (sel_reg == `DPF_SEL_DATA);
	wire key1_wr = unl_wr && (port_req_i.wdata == `DPF_KEY_FIRST);
	wire key2_wr = unl_wr && (port_req_i.wdata == `DPF_KEY_SECOND);
	wire cmd_ok = dat_wr && prog_en_reg && (cmd_state_reg == C_IDLE);
	wire is_block = (cmd_op_reg == FOP_READ) || (cmd_op_reg == FOP_WRITE);
	wire last_byte = (count_reg == `DPF_CNT_ONE);
	wire [8:0] len_cnt = (port_req_i.wdata == `DPF_RST_BYTE) ? `DPF_CNT_FULL
		: {1'b0, port_req_i.wdata};

	// Read selection; identity registers ignore writes
	assign rdata_next = (sel_reg == `DPF_SEL_DEVID) ? `DPF_DEV_ID
		: (sel_reg == `DPF_SEL_REVID) ? `DPF_REV_ID
		: (sel_reg == `DPF_SEL_UNLOCK) ? unlock_reg
		: (sel_reg == `DPF_SEL_DATA) ? data_reg
		: `DPF_RST_BYTE;

	// ---------------------------------------------
	// Unlock sequence
	// ---------------------------------------------
	// Ordered pair opens; a repeated first key keeps, any other code drops a partial sequence
	always_comb
	begin
		unl_state_next = unl_state_reg;
		unlock_next = unl_wr ? port_req_i.wdata : unlock_reg;
		unique case (unl_state_reg)
			UNL_LOCKED:
			begin
				if (key1_wr)
					unl_state_next = UNL_FIRST;
			end
			UNL_FIRST:
			begin
				if (key2_wr)
					unl_state_next = UNL_OPEN;
				else if (key1_wr)
					unl_state_next = UNL_FIRST;
				else if (unl_wr)
					unl_state_next = UNL_LOCKED;
			end
			UNL_OPEN:
				unl_state_next = UNL_OPEN;
			default:
				unl_state_next = UNL_LOCKED;
		endcase
	end

	// ---------------------------------------------
	// Command engine
	// ---------------------------------------------
	// Parses command, address, length and data bytes
	always_comb
	begin
		cmd_state_next = cmd_state_reg;
		cmd_op_next = cmd_op_reg;
		faddr_next = faddr_reg;
		count_next = count_reg;
		data_next = dat_wr ? port_req_i.wdata : data_reg;
		freq_next = freq_reg;
		start = 1'b0;
		unique case (cmd_state_reg)
			C_IDLE:
			begin
				if (cmd_ok)
				begin
					cmd_state_next = C_ADDR_HI;
					if (port_req_i.wdata == `DPF_CMD_ERASE_ALL)
					begin
						cmd_op_next = FOP_ERASE_ALL;
						cmd_state_next = C_FLASH;
						start = 1'b1;
					end
					else if (port_req_i.wdata == `DPF_CMD_PAGE_ERASE)
						cmd_op_next = FOP_PAGE_ERASE;
					else if (port_req_i.wdata == `DPF_CMD_READ)
						cmd_op_next = FOP_READ;
					else if (port_req_i.wdata == `DPF_CMD_WRITE)
						cmd_op_next = FOP_WRITE;
					else
						cmd_state_next = C_IDLE;
				end
			end
			C_ADDR_HI:
			begin
				if (dat_wr)
				begin
					faddr_next = {port_req_i.wdata, faddr_reg[7:0]};
					cmd_state_next = C_ADDR_LO;
				end
			end
			C_ADDR_LO:
			begin
				if (dat_wr)
				begin
					faddr_next = {faddr_reg[15:8], port_req_i.wdata};
					cmd_state_next = is_block ? C_LEN : C_FLASH;
					start = !is_block;
				end
			end
			C_LEN:
			begin
				if (dat_wr)
				begin
					count_next = len_cnt;
					start = (cmd_op_reg == FOP_READ);
					cmd_state_next = start ? C_FLASH : C_DATA;
				end
			end
			C_DATA:
			begin
				// Write waits for a byte, read waits for the host to take one
				start = (cmd_op_reg == FOP_WRITE) ? dat_wr : dat_rd;
				if (start)
					cmd_state_next = C_FLASH;
			end
			C_FLASH:
			begin
				if (flash_done_i)
				begin
					freq_next.valid = 1'b0;
					cmd_state_next = C_IDLE;
					// Flash data wins over a host write in the same cycle
					if (cmd_op_reg == FOP_READ)
						data_next = flash_rdata_i;
					if (is_block)
					begin
						faddr_next = faddr_reg + `DPF_ADDR_ONE;
						count_next = count_reg - `DPF_CNT_ONE;
						cmd_state_next = last_byte ? C_IDLE : C_DATA;
					end
				end
			end
			default:
				cmd_state_next = C_IDLE;
		endcase
		if (start)
		begin
			freq_next.valid = 1'b1;
			freq_next.op = cmd_op_next;
			freq_next.addr = faddr_next;
			freq_next.wdata = port_req_i.wdata;
		end
	end

	// ---------------------------------------------
	// Registers
	// ---------------------------------------------
	// Port select and unlock state
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			sel_reg <= `DPF_RST_BYTE;
			unlock_reg <= `DPF_RST_BYTE;
			unl_state_reg <= UNL_LOCKED;
			prog_en_reg <= 1'b0;
		end
		else
		begin
			if (port_req_i.addr_wr)
				sel_reg <= port_req_i.wdata;
			unlock_reg <= unlock_next;
			unl_state_reg <= unl_state_next;
			prog_en_reg <= (unl_state_next == UNL_OPEN);
		end
	end

	// Command engine and flash request
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			cmd_state_reg <= C_IDLE;
			cmd_op_reg <= FOP_ERASE_ALL;
			faddr_reg <= `DPF_RST_ADDR;
			count_reg <= `DPF_RST_CNT;
			data_reg <= `DPF_RST_BYTE;
			freq_reg <= '0;
			busy_reg <= 1'b0;
		end
		else
		begin
			cmd_state_reg <= cmd_state_next;
			cmd_op_reg <= cmd_op_next;
			faddr_reg <= faddr_next;
			count_reg <= count_next;
			data_reg <= data_next;
			freq_reg <= freq_next;
			busy_reg <= (cmd_state_next != C_IDLE);
		end
	end

	// Read answer, one cycle after the strobe
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			rdata_reg <= `DPF_RST_BYTE;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rdata_reg <= port_req_i.data_rd ? rdata_next : rdata_reg;
			rvalid_reg <= port_req_i.data_rd;
		end
	end

	assign rdata_o = rdata_reg;
	assign rvalid_o = rvalid_reg;
	assign prog_enable_o = prog_en_reg;
	assign busy_o = busy_reg;
	assign flash_req_o = freq_reg;

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_key1;
		key1_wr && (unl_state_reg == UNL_LOCKED);
	endsequence
	sequence s_key2;
		key2_wr;
	endsequence
	sequence s_rd_devid;
		port_req_i.data_rd && (sel_reg == `DPF_SEL_DEVID);
	endsequence

	chk_devid_fixed: assert property (s_rd_devid |=> rvalid_o && rdata_o == `DPF_DEV_ID)
		else $error("device code read wrong");
	chk_revid_fixed: assert property (port_req_i.data_rd && sel_reg == `DPF_SEL_REVID
		|=> rdata_o == `DPF_REV_ID)
		else $error("revision code read wrong");
	chk_unlock_only: assert property ($rose(prog_en_reg)
		|-> $past(key2_wr) && $past(unl_state_reg) == UNL_FIRST)
		else $error("programming enabled without unlock");
	chk_unlock_pair: assert property (s_key1 ##1 s_key2 |=> prog_enable_o)
		else $error("ordered pair did not enable");
	chk_prog_sticky: assert property (prog_enable_o |=> prog_enable_o)
		else $error("programming mode dropped");
	chk_data_store: assert property (dat_wr && cmd_state_reg != C_FLASH
		|=> data_reg == $past(port_req_i.wdata))
		else $error("data register not written");
	chk_erase_all: assert property (cmd_ok && port_req_i.wdata == `DPF_CMD_ERASE_ALL
		|=> flash_req_o.valid && flash_req_o.op == FOP_ERASE_ALL)
		else $error("device erase not issued");
	chk_block_write: assert property (cmd_ok && port_req_i.wdata == `DPF_CMD_WRITE
		|=> cmd_state_reg == C_ADDR_HI && cmd_op_reg == FOP_WRITE)
		else $error("block write not started");
	chk_sel_steer: assert property (port_req_i.addr_wr && port_req_i.wdata == `DPF_SEL_UNLOCK
		##1 port_req_i.data_rd && !port_req_i.data_wr |=> rdata_o == unlock_reg)
		else $error("select did not steer read");
	chk_wrong_code: assert property (unl_state_reg == UNL_FIRST && unl_wr && !key1_wr
		&& !key2_wr |=> unl_state_reg == UNL_LOCKED ##1 !prog_enable_o)
		else $error("wrong code kept partial unlock");
endmodule

// file: dpf_flash_model.sv
// Behavioural flash controller facing the programming register block.
// Assumes one clock; the bench sets the answer latency, at least one cycle.
module dpf_flash_model
	import dpf_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Request and answer
	input wire dpf_flash_req_t req_i,
	input wire logic [3:0] lat_i,
	output logic done_o,
	output logic [7:0] rdata_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_reg;
	logic [7:0] byte_val;

	// Count while a request stands, clear after the single answer
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i || !req_i.valid || done_o)
			cnt_reg <= 4'h0;
		else
			cnt_reg <= cnt_reg + 4'h1;
	end

	// Read byte only valid with done; otherwise its inverse, never a stale copy
	assign byte_val = req_i.addr[7:0] ^ 8'h3c;
	assign done_o = req_i.valid && (cnt_reg == lat_i);
	assign rdata_o = done_o ? byte_val : ~byte_val;
endmodule

// file: debug_port_flash_prog_registers_tb.sv
// Self-checking bench for the debug-port flash programming registers.
// Assumes dpf_prog_regs and dpf_flash_model are compiled before it.
`include "dpf_defs.svh"
module debug_port_flash_prog_registers_tb
	import dpf_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [7:0] sel; logic wr; logic [7:0] wd; logic [7:0] exp;} dpf_row_t;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	dpf_port_req_t port_req = '0;
	dpf_flash_req_t freq;
	logic [7:0] rdata;
	logic [7:0] frd;
	logic [7:0] rd_v;
	logic rvalid;
	logic prog_en;
	logic busy;
	logic done;
	logic [3:0] lat = 4'h1;
	int n_fail = 0;
	int samples_checked = 0;
	// Register table: select, write, byte written, byte read back
	dpf_row_t rows [7] = '{
		'{`DPF_SEL_DEVID, 1'b1, 8'hff, `DPF_DEV_ID},
		'{`DPF_SEL_REVID, 1'b1, 8'hff, `DPF_REV_ID},
		'{`DPF_SEL_UNLOCK, 1'b0, 8'h00, 8'h00},
		'{`DPF_SEL_DATA, 1'b0, 8'h00, 8'h00},
		'{8'h7e, 1'b1, 8'h11, 8'h00},
		'{`DPF_SEL_UNLOCK, 1'b1, `DPF_KEY_SECOND, `DPF_KEY_SECOND},
		'{`DPF_SEL_DATA, 1'b1, `DPF_CMD_ERASE_ALL, `DPF_CMD_ERASE_ALL}};

	// Clock
	always #12.5 ref_clk_i = ~ref_clk_i;

	dpf_prog_regs dpf_prog_regs_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .port_req_i(port_req),
		.rdata_o(rdata), .rvalid_o(rvalid), .prog_enable_o(prog_en), .busy_o(busy),
		.flash_req_o(freq), .flash_done_i(done), .flash_rdata_i(frd));
	dpf_flash_model dpf_flash_model_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(freq),
		.lat_i(lat), .done_o(done), .rdata_o(frd));

	// ---------------------------------------------
	// Tasks
	// ---------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One-cycle port strobe, launched just after an edge
	task automatic port(input logic a, input logic w, input logic r, input logic [7:0] d);
		@(posedge ref_clk_i);
		#2;
		port_req = '{addr_wr: a, data_wr: w, data_rd: r, wdata: d};
		@(posedge ref_clk_i);
		#2;
		port_req = '0;
	endtask

	task automatic rd(output logic [7:0] v);
		port(1'b0, 1'b0, 1'b1, 8'h00);
		check(rvalid, 1'b1, "read strobe");
		v = rdata;
	endtask

	// Two strobes on consecutive edges, back to back
	task automatic port2(input dpf_port_req_t p, input dpf_port_req_t q);
		@(posedge ref_clk_i);
		#2;
		port_req = p;
		@(posedge ref_clk_i);
		#2;
		port_req = q;
		@(posedge ref_clk_i);
		#2;
		port_req = '0;
	endtask

	// Select a register and read it on the very next edge
	task automatic sel_rd(input logic [7:0] s, output logic [7:0] v);
		port2('{addr_wr: 1'b1, data_wr: 1'b0, data_rd: 1'b0, wdata: s},
			'{addr_wr: 1'b0, data_wr: 1'b0, data_rd: 1'b1, wdata: 8'h00});
		check(rvalid, 1'b1, "read strobe");
		v = rdata;
	endtask

	// Command, address high then low, length unless page erase
	task automatic hdr(input logic [7:0] c, input logic [15:0] a, input logic [7:0] n);
		port(1'b0, 1'b1, 1'b0, c);
		port(1'b0, 1'b1, 1'b0, a[15:8]);
		port(1'b0, 1'b1, 1'b0, a[7:0]);
		if (c != `DPF_CMD_PAGE_ERASE)
			port(1'b0, 1'b1, 1'b0, n);
	endtask

	task automatic wait_op(input dpf_fop_t op, input logic [15:0] a, input logic [7:0] wd);
		int n = 0;
		do
		begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		while (done !== 1'b1 && n < 40);
		check(done, 1'b1, "flash done");
		check(busy, 1'b1, "busy in op");
		check(freq.op, op, "flash op");
		if (op != FOP_ERASE_ALL)
			check(freq.addr, a, "flash addr");
		if (op == FOP_WRITE)
			check(freq.wdata, wd, "flash byte");
		// Let the engine take done before the latency or the strobes change
		@(posedge ref_clk_i);
		#1;
		check(freq.valid, 1'b0, "request dropped");
	endtask

	task automatic do_reset();
		@(posedge ref_clk_i);
		#2;
		rst_i = 1'b1;
		repeat (8) @(posedge ref_clk_i);
		#2;
		rst_i = 1'b0;
	endtask

	task automatic results();
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ---------------------------------------------
	// Tests
	// ---------------------------------------------
	initial
	begin
		do_reset();
		foreach (rows[i])
		begin
			port(1'b1, 1'b0, 1'b0, rows[i].sel);
			if (rows[i].wr)
				port(1'b0, 1'b1, 1'b0, rows[i].wd);
			rd(rd_v);
			check(rd_v, rows[i].exp, "register read");
			check(prog_en, 1'b0, "locked");
			check(busy, 1'b0, "idle while locked");
		end
		$display("register table done");
		port(1'b1, 1'b0, 1'b0, `DPF_SEL_UNLOCK);
		port(1'b0, 1'b1, 1'b0, `DPF_KEY_FIRST);
		port(1'b0, 1'b1, 1'b0, 8'h05);
		port(1'b0, 1'b1, 1'b0, `DPF_KEY_SECOND);
		@(posedge ref_clk_i);
		#2;
		check(prog_en, 1'b0, "broken pair");
		port2('{addr_wr: 1'b0, data_wr: 1'b1, data_rd: 1'b0, wdata: `DPF_KEY_FIRST},
			'{addr_wr: 1'b0, data_wr: 1'b1, data_rd: 1'b0, wdata: `DPF_KEY_SECOND});
		@(posedge ref_clk_i);
		#2;
		check(prog_en, 1'b1, "unlocked");
		$display("unlock done");
		port(1'b1, 1'b0, 1'b0, `DPF_SEL_DATA);
		lat = 4'h3;
		port(1'b0, 1'b1, 1'b0, `DPF_CMD_ERASE_ALL);
		wait_op(FOP_ERASE_ALL, 16'h0000, 8'h00);
		hdr(`DPF_CMD_PAGE_ERASE, 16'h1234, 8'h00);
		wait_op(FOP_PAGE_ERASE, 16'h1234, 8'h00);
		lat = 4'h1;
		hdr(`DPF_CMD_WRITE, 16'h01ff, 8'h02);
		for (int k = 0; k < 2; k++)
		begin
			port(1'b0, 1'b1, 1'b0, 8'ha0 + 8'(k));
			wait_op(FOP_WRITE, 16'h01ff + 16'(k), 8'ha0 + 8'(k));
		end
		lat = 4'h2;
		hdr(`DPF_CMD_READ, 16'h00fe, 8'h02);
		for (int k = 0; k < 2; k++)
		begin
			wait_op(FOP_READ, 16'h00fe + 16'(k), 8'h00);
			rd(rd_v);
			check(rd_v, (8'hfe + 8'(k)) ^ 8'h3c, "read byte");
		end
		port(1'b0, 1'b1, 1'b0, 8'h09);
		repeat (2) @(posedge ref_clk_i);
		#2;
		check(busy, 1'b0, "unknown command");
		$display("flash commands done");
		port(1'b1, 1'b0, 1'b0, `DPF_SEL_UNLOCK);
		port(1'b0, 1'b1, 1'b0, 8'h00);
		@(posedge ref_clk_i);
		#2;
		check(prog_en, 1'b1, "sticky mode");
		do_reset();
		check(prog_en, 1'b0, "mode after reset");
		sel_rd(`DPF_SEL_UNLOCK, rd_v);
		check(rd_v, 8'h00, "unlock after reset");
		$display("reset test done");
		results();
	end

	// Watchdog
	initial
	begin
		#100000;
		n_fail++;
		results();
	end
endmodule
